/* design/irl_pkg.sv */
// package: register map, field positions and reset values of the request latch
package irl_pkg;
    localparam logic [11:0] REQ_FLAGS_OFFSET  = 12'hfc0;
    localparam logic [11:0] CTRL_OFFSET       = 12'hfc4;
    localparam logic [11:0] ENABLE_OFFSET     = 12'hfc8;
    localparam logic [11:0] PRIORITY_OFFSET   = 12'hfcc;
    localparam logic [11:0] EVT_STATUS_OFFSET = 12'hfd0;
    localparam logic [11:0] EVT_MASK_OFFSET   = 12'hfd4;
    localparam logic [11:0] RESET_CAUSE_OFFSET = 12'hfd8;
    localparam logic [7:0]  REQ_FLAGS_RESET   = 8'h00;
    localparam logic [7:0]  ENABLE_RESET      = 8'h00;
    localparam logic [7:0]  PRIORITY_RESET    = 8'h00;
    localparam logic [7:0]  EVT_RESET         = 8'h00;
    localparam logic [7:0]  REQ_VALID_MASK    = 8'h79;
    localparam int          TIMER1_BIT        = 6;
    localparam int          TIMER0_BIT        = 5;
    localparam int          SER0_RX_BIT       = 4;
    localparam int          SER0_TX_BIT       = 3;
    localparam int          CONVERTER_BIT     = 0;
    localparam int          GLOBAL_EN_BIT     = 7;
    localparam int          WDT_CAUSE_BIT     = 5;
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;
    typedef logic [7:0] irl_byte_t;
endpackage

/* design/irl_req_if.sv */
// interface: request flags and forward path between latch core and top
`timescale 1ns/1ns
interface irl_req_if;
    logic [7:0] flags;
    logic [7:0] enable;
    logic       global_en;
    logic [7:0] forward;
    modport core (output flags, forward, input enable, global_en);
    modport top  (input flags, forward, output enable, global_en);
endinterface

/* design/irl_flag_core.sv */
// module: request flag latch with software write and vectored forwarding
`timescale 1ns/1ns
module irl_flag_core
    import irl_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire logic      ce,
    input  wire irl_pkg::irl_byte_t src_req,
    input  wire logic      sw_we,
    input  wire irl_pkg::irl_byte_t sw_data,
    irl_req_if.core        rq
);
    irl_byte_t flags;
    irl_byte_t next_flags;

    // =======================================
    // flag latch
    always_comb begin
        next_flags = flags;
        if (sw_we) begin
            next_flags = sw_data & REQ_VALID_MASK;
        end
        // set wins over a software clear in the same cycle
        next_flags = next_flags | (src_req & REQ_VALID_MASK);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= REQ_FLAGS_RESET;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    assign rq.flags   = flags;
    // only forwarded while globally enabled; otherwise software polls
    assign rq.forward = rq.global_en ? (flags & rq.enable) : 8'h00;

    AST_SET_SEEN: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && src_req[TIMER1_BIT] |=> flags[TIMER1_BIT])
        else $error("timer1 request not latched");
    AST_T0_SEEN: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && src_req[TIMER0_BIT] |=> flags[TIMER0_BIT])
        else $error("timer0 request not latched");
    AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        (flags & ~REQ_VALID_MASK) == 8'h00)
        else $error("reserved flag bit set");
endmodule

/* design/irl_top.sv */
// module: interrupt request latch with AXI4-Lite register access
`timescale 1ns/1ns
// Notes on behaviour
// - 8-bit request register at fc0, resets zero
// - source request on bits 0 and 3 to 6 sets its flag bit; requests on bits 1, 2 and 7 are dropped
// - globally enabled: forward pending requests whose enable bit is set to core
// - globally disabled: no forward, flags stay readable
// - bit 6 flags timer 1 request
// - bit 5 flags timer 0 request
// - control registers enable, prioritise, flag interrupts (priority register is only stored and read back; it steers nothing)
// - watchdog and oscillator traps bypass these registers
// - reading reset cause clears watchdog bit 5
module irl_top
    import irl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  src_req,
    input  wire logic        wdt_cause_set,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [7:0]       core_irq_req,
    output logic             irq
);
    import irl_pkg::*;

    irl_req_if rq ();

    // =======================================
    // register state
    logic            global_en;
    irl_byte_t       enable;
    irl_byte_t       priority_sel;
    irl_byte_t       evt_status;
    irl_byte_t       evt_mask;
    logic            wdt_cause;
    logic            aw_held;
    logic            w_held;
    logic [11:0]     aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            next_global_en;
    irl_byte_t       next_enable;
    irl_byte_t       next_priority_sel;
    irl_byte_t       next_evt_status;
    irl_byte_t       next_evt_mask;
    logic            next_wdt_cause;
    logic            next_aw_held;
    logic            next_w_held;
    logic [11:0]     next_aw_addr;
    logic [31:0]     next_w_data;
    logic [3:0]      next_w_strb;
    logic            next_bvalid;
    logic [1:0]      next_bresp;
    logic            next_rvalid;
    logic [31:0]     next_rdata;
    logic [1:0]      next_rresp;
    logic            next_awready;
    logic            next_wready;
    logic            next_arready;
    irl_byte_t       next_core_irq_req;
    logic            next_irq;
    logic            wr_fire;
    logic            rd_fire;
    logic            req_we;
    irl_byte_t       req_wdata;
    irl_byte_t       forward_d;
    irl_byte_t       new_req;

    function automatic logic known(input logic [11:0] a);
        known = (a == REQ_FLAGS_OFFSET) || (a == CTRL_OFFSET) || (a == ENABLE_OFFSET)
             || (a == PRIORITY_OFFSET) || (a == EVT_STATUS_OFFSET)
             || (a == EVT_MASK_OFFSET) || (a == RESET_CAUSE_OFFSET);
    endfunction

    assign rq.enable    = enable;
    assign rq.global_en = global_en;

    irl_flag_core u_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .src_req (src_req),
        .sw_we   (req_we),
        .sw_data (req_wdata),
        .rq      (rq)
    );

    // =======================================
    // bus handshake and register update
    always_comb begin
        next_global_en    = global_en;
        next_enable       = enable;
        next_priority_sel = priority_sel;
        next_evt_status   = evt_status;
        next_evt_mask     = evt_mask;
        next_wdt_cause    = wdt_cause;
        next_aw_held      = aw_held;
        next_w_held       = w_held;
        next_aw_addr      = aw_addr;
        next_w_data       = w_data;
        next_w_strb       = w_strb;
        next_bvalid       = s_axi_bvalid;
        next_bresp        = s_axi_bresp;
        next_rvalid       = s_axi_rvalid;
        next_rdata        = s_axi_rdata;
        next_rresp        = s_axi_rresp;
        req_we            = 1'b0;
        req_wdata         = rq.flags;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        wr_fire = aw_held && w_held && !s_axi_bvalid;
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (w_strb[0]) begin
                unique case (aw_addr)
                    // bit 7 kept zero whatever software writes
                    REQ_FLAGS_OFFSET: begin
                        req_we    = 1'b1;
                        req_wdata = w_data[7:0];
                    end
                    CTRL_OFFSET:     next_global_en    = w_data[GLOBAL_EN_BIT];
                    ENABLE_OFFSET:   next_enable       = w_data[7:0];
                    PRIORITY_OFFSET: next_priority_sel = w_data[7:0];
                    EVT_STATUS_OFFSET: next_evt_status = evt_status & ~w_data[7:0];
                    EVT_MASK_OFFSET: next_evt_mask     = w_data[7:0];
                    default: ;
                endcase
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        rd_fire = s_axi_arvalid && s_axi_arready;
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp  = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            next_rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                REQ_FLAGS_OFFSET:  next_rdata[7:0] = rq.flags;
                CTRL_OFFSET:       next_rdata[GLOBAL_EN_BIT] = global_en;
                ENABLE_OFFSET:     next_rdata[7:0] = enable;
                PRIORITY_OFFSET:   next_rdata[7:0] = priority_sel;
                EVT_STATUS_OFFSET: next_rdata[7:0] = evt_status;
                EVT_MASK_OFFSET:   next_rdata[7:0] = evt_mask;
                RESET_CAUSE_OFFSET: begin
                    next_rdata[WDT_CAUSE_BIT] = wdt_cause;
                    next_wdt_cause = 1'b0;
                end
                default: ;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // watchdog cause is kept outside the request flags
        if (wdt_cause_set) begin
            next_wdt_cause = 1'b1;
        end
        new_req         = src_req & REQ_VALID_MASK & ~rq.flags;
        next_evt_status = next_evt_status | new_req;
        next_awready    = !next_aw_held && !(s_axi_awvalid && s_axi_awready);
        next_wready     = !next_w_held && !(s_axi_wvalid && s_axi_wready);
        next_arready    = !next_rvalid;
        forward_d       = rq.forward;
        next_core_irq_req = forward_d;
        // new mask takes effect in the same cycle as new status, so irq tracks both
        next_irq        = |(next_evt_status & next_evt_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_en     <= 1'b0;
            enable        <= ENABLE_RESET;
            priority_sel  <= PRIORITY_RESET;
            evt_status    <= EVT_RESET;
            evt_mask      <= EVT_RESET;
            wdt_cause     <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            core_irq_req  <= 8'h00;
            irq           <= 1'b0;
        end else if (ce) begin
            global_en     <= next_global_en;
            enable        <= next_enable;
            priority_sel  <= next_priority_sel;
            evt_status    <= next_evt_status;
            evt_mask      <= next_evt_mask;
            wdt_cause     <= next_wdt_cause;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
            core_irq_req  <= next_core_irq_req;
            irq           <= next_irq;
        end
    end

    // =======================================
    // checks
    AST_RESET_ZERO: assert property (@(posedge aclk)
        $rose(aresetn) |-> rq.flags == REQ_FLAGS_RESET)
        else $error("request flags not zero after reset");
    AST_FORWARD_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && global_en && |(rq.flags & enable) |=> core_irq_req != 8'h00)
        else $error("enabled request not forwarded");
    AST_FORWARD_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !global_en |=> core_irq_req == 8'h00)
        else $error("request forwarded while disabled");
    AST_POLL_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && rd_fire && s_axi_araddr == REQ_FLAGS_OFFSET
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(rq.flags))
        else $error("polled flags read wrong");
    AST_BIT7_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        !rq.flags[7])
        else $error("reserved top flag set");
    AST_CAUSE_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && rd_fire && s_axi_araddr == RESET_CAUSE_OFFSET && !wdt_cause_set
        |=> !wdt_cause)
        else $error("watchdog cause not cleared by read");
    AST_CAUSE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wdt_cause_set |=> wdt_cause
        && (rq.flags[WDT_CAUSE_BIT] == ($past(req_we) ? $past(req_wdata[WDT_CAUSE_BIT])
                                                      : $past(rq.flags[WDT_CAUSE_BIT]))
            || $past(src_req[WDT_CAUSE_BIT])))
        else $error("watchdog cause leaked into request flags");
    AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wr_fire |=> s_axi_bvalid)
        else $error("write not answered");
    AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> irq == |(evt_status & evt_mask))
        else $error("interrupt level wrong");

    COV_FORWARD: cover property (@(posedge aclk) global_en && core_irq_req != 8'h00);
    COV_POLL: cover property (@(posedge aclk) !global_en && rq.flags != 8'h00 && rd_fire);
    COV_CLEAR: cover property (@(posedge aclk) wr_fire && aw_addr == REQ_FLAGS_OFFSET);
    COV_CAUSE: cover property (@(posedge aclk) wdt_cause ##1 !wdt_cause);
endmodule

/* test/irl_core_model.sv */
// model: processor core that services the highest forwarded request
`timescale 1ns/1ns
module irl_core_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] irq_req,
    output logic [2:0]      vec,
    output logic            active
);
    // ==========================================
    // vector pick
    logic [2:0] next_vec;
    logic       next_active;
    // highest index wins, a stand-in for the priority logic of the core
    always_comb begin
        next_vec = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (irq_req[i]) begin
                next_vec = i[2:0];
            end
        end
        next_active = |irq_req;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec    <= 3'h0;
            active <= 1'b0;
        end else begin
            vec    <= next_vec;
            active <= next_active;
        end
    end
endmodule

/* test/interrupt_request_latch_test.sv */
// testbench: register access, request latching, forwarding and events
`timescale 1ns/1ns
module interrupt_request_latch_test;
    import irl_pkg::*;
    logic        aclk, aresetn, ce, wdt_cause_set, irq, core_active;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    logic [2:0]  core_vec;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  src_req, core_irq_req;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    int          miscompares, tests_run, cycles;

    // ==========================================
    // instances
    irl_top irl_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .src_req(src_req), .wdt_cause_set(wdt_cause_set),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_irq_req(core_irq_req), .irq(irq)
    );
    irl_core_model irl_core_model_inst (
        .aclk(aclk), .aresetn(aresetn), .irq_req(core_irq_req), .vec(core_vec), .active(core_active)
    );

    // ==========================================
    // common tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        axi_rd(a);
        check(rd_data, e);
        check(32'(rd_resp), 32'(RESP_OKAY));
    endtask
    task automatic pulse(input logic [7:0] v);
        src_req <= v;
        @(posedge aclk);
        src_req <= 8'h00;
        @(posedge aclk);
    endtask
    // outputs are registered, so allow a few cycles before judging
    task automatic wait_out(input logic [7:0] ec, input logic ei);
        int n;
        n = 0;
        while ((core_irq_req !== ec || irq !== ei) && n < 8) begin
            @(posedge aclk);
            n++;
        end
        check(32'(core_irq_req), 32'(ec));
        check(32'(irq), 32'(ei));
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rd_chk(REQ_FLAGS_OFFSET, 32'(REQ_FLAGS_RESET));
        rd_chk(CTRL_OFFSET, 32'h0);
        rd_chk(ENABLE_OFFSET, 32'(ENABLE_RESET));
        rd_chk(PRIORITY_OFFSET, 32'(PRIORITY_RESET));
        rd_chk(EVT_STATUS_OFFSET, 32'(EVT_RESET));
        wait_out(8'h00, 1'b0);
    endtask
    task automatic t_sources();
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            rd_chk(REQ_FLAGS_OFFSET, 32'(8'h79 & (8'h01 << i)));
            wr(REQ_FLAGS_OFFSET, 32'h0);
        end
        wr(REQ_FLAGS_OFFSET, 32'h7f);
        rd_chk(REQ_FLAGS_OFFSET, 32'h79);
        wr(REQ_FLAGS_OFFSET, 32'h0);
        rd_chk(REQ_FLAGS_OFFSET, 32'h0);
    endtask
    task automatic t_forward();
        pulse(8'h28);
        wr(ENABLE_OFFSET, 32'hff);
        wait_out(8'h00, 1'b0);
        rd_chk(REQ_FLAGS_OFFSET, 32'h28);
        wr(CTRL_OFFSET, 32'h80);
        wait_out(8'h28, 1'b0);
        @(posedge aclk);
        check(32'(core_vec), 32'd5);
        check(32'(core_active), 32'd1);
        wr(ENABLE_OFFSET, 32'h08);
        wait_out(8'h08, 1'b0);
        wr(PRIORITY_OFFSET, 32'h5a);
        rd_chk(PRIORITY_OFFSET, 32'h5a);
        wr(CTRL_OFFSET, 32'h0);
        wait_out(8'h00, 1'b0);
        wr(REQ_FLAGS_OFFSET, 32'h0);
        wr(ENABLE_OFFSET, 32'h0);
    endtask
    task automatic t_events();
        wr(EVT_STATUS_OFFSET, 32'hff);
        wr(EVT_MASK_OFFSET, 32'h20);
        rd_chk(EVT_STATUS_OFFSET, 32'h0);
        pulse(8'h40);
        wait_out(8'h00, 1'b0);
        pulse(8'h20);
        wait_out(8'h00, 1'b1);
        rd_chk(EVT_STATUS_OFFSET, 32'h60);
        wr(EVT_STATUS_OFFSET, 32'h20);
        wait_out(8'h00, 1'b0);
        wr(EVT_MASK_OFFSET, 32'h40);
        wait_out(8'h00, 1'b1);
        wr(EVT_STATUS_OFFSET, 32'h40);
        wait_out(8'h00, 1'b0);
        wr(EVT_MASK_OFFSET, 32'h0);
        // flags stay set until software clears them
        rd_chk(REQ_FLAGS_OFFSET, 32'h60);
        wr(REQ_FLAGS_OFFSET, 32'h0);
    endtask
    task automatic t_cause();
        wdt_cause_set <= 1'b1;
        @(posedge aclk);
        wdt_cause_set <= 1'b0;
        @(posedge aclk);
        rd_chk(RESET_CAUSE_OFFSET, 32'h20);
        rd_chk(RESET_CAUSE_OFFSET, 32'h0);
        rd_chk(REQ_FLAGS_OFFSET, 32'h0);
        wait_out(8'h00, 1'b0);
    endtask
    task automatic t_unmapped();
        wr(12'h100, 32'h1, RESP_SLVERR);
        axi_rd(12'h100);
        check(rd_data, 32'h0);
        check(32'(rd_resp), 32'(RESP_SLVERR));
        rd_chk(REQ_FLAGS_OFFSET, 32'h0);
    endtask
    // second reset in mid-run, with requests pending and forwarding on
    task automatic t_reset_again();
        pulse(8'h41);
        wr(ENABLE_OFFSET, 32'hff);
        wr(CTRL_OFFSET, 32'h80);
        wait_out(8'h41, 1'b0);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(REQ_FLAGS_OFFSET, 32'(REQ_FLAGS_RESET));
        rd_chk(CTRL_OFFSET, 32'h0);
        wait_out(8'h00, 1'b0);
        check(32'(core_active), 32'd0);
    endtask

    // ==========================================
    // clock, timeout and main sequence
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        {aclk, aresetn, wdt_cause_set, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, src_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        ce = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_sources();
        t_forward();
        t_events();
        t_cause();
        t_unmapped();
        t_reset_again();
        wrap_up();
    end
endmodule
